//--- hdl/rsse_exec.sv
/*
  Execution block for rotate-left-through-carry, subtract-from-literal,
  subtract-from-file and power-down. Holds the time-out and power-down
  flags, a watchdog counter with prescaler, and the oscillator run line.
  Assumes the fetch unit presents one instruction with its operands on
  core_clk and reads back one-cycle write strobes; wake_pin is external.
*/
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
module rsse_exec
  import rsse_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic [7:0] w_in,
  input wire logic [7:0] file_in,
  input wire logic carry_in,
  input wire logic wake_pin,
  output logic instr_done_q,
  output logic w_we_q,
  output logic f_we_q,
  output logic [6:0] f_addr_q,
  output logic [7:0] wb_data_q,
  output logic c_we_q,
  output logic dcz_we_q,
  output logic flag_c_q,
  output logic digit_carry_flag_q,
  output logic flag_z_q,
  output logic timeout_flag_q,
  output logic power_down_flag_q,
  output logic osc_run_q,
  output logic sleep_q,
  output logic [7:0] watchdog_counter_q,
  output logic [7:0] wdt_presc_q,
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  // ****************************************************************
  // Decode.
  // ****************************************************************
  rsse_state_t state_q;
  logic go;
  logic is_rot;
  logic is_subf;
  logic is_subl;
  logic is_sleep;
  logic to_file;
  rsse_alu_t alu_op;
  logic [7:0] alu_a;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic wake_s1_q;
  logic wake_s2_q;
  logic wden_q;
  logic wr_fire;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [3:0] rd_addr;
  logic [31:0] rd_data;

  // Issue is blocked while halted so nothing executes with the clock off.
  assign go = instr_valid && (state_q == RSSE_RUN);
  assign is_rot = (instr_word[13:8] == OP_ROT);
  assign is_subf = (instr_word[13:8] == OP_SUBF);
  assign is_subl = (instr_word[13:9] == OP_SUBL);
  assign is_sleep = (instr_word == OP_SLEEP);
  assign to_file = instr_word[DEST_BIT];
  assign alu_op = is_rot ? RSSE_ALU_ROT : RSSE_ALU_SUB;
  // The literal replaces the file operand for the literal subtract.
  assign alu_a = is_subl ? instr_word[7:0] : file_in;

  rsse_alu u_alu (
    .op(alu_op),
    .a(alu_a),
    .w(w_in),
    .c_in(carry_in),
    .res(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z)
  );

  // ****************************************************************
  // Write-back and flags, all settled in the cycle after issue.
  // ****************************************************************

  // Destination strobes; the literal form never touches the file.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instr_done_q <= 1'h0;
      w_we_q <= 1'h0;
      f_we_q <= 1'h0;
      f_addr_q <= 7'h00;
      wb_data_q <= 8'h00;
    end
    else if (clk_en)
    begin
      instr_done_q <= go && (is_rot || is_subf || is_subl || is_sleep);
      w_we_q <= go && (is_subl || ((is_rot || is_subf) && !to_file));
      f_we_q <= go && (is_rot || is_subf) && to_file;
      f_addr_q <= instr_word[FA_W-1:0];
      wb_data_q <= alu_res;
    end
  end

  // Status flags; rotate reports carry only, subtracts report all three.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c_we_q <= 1'h0;
      dcz_we_q <= 1'h0;
      flag_c_q <= 1'h0;
      digit_carry_flag_q <= 1'h0;
      flag_z_q <= 1'h0;
    end
    else if (clk_en)
    begin
      c_we_q <= go && (is_rot || is_subf || is_subl);
      dcz_we_q <= go && (is_subf || is_subl);
      if (go && (is_rot || is_subf || is_subl))
      begin
        flag_c_q <= alu_c;
      end
      if (go && (is_subf || is_subl))
      begin
        digit_carry_flag_q <= alu_dc;
        flag_z_q <= alu_z;
      end
    end
  end

  // ****************************************************************
  // Power-down: flags, run state and the wake synchroniser.
  // ****************************************************************

  // Wake arrives from a pin, so it passes two flops first.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_s1_q <= 1'h0;
      wake_s2_q <= 1'h0;
    end
    else if (clk_en)
    begin
      wake_s1_q <= wake_pin;
      wake_s2_q <= wake_s1_q;
    end
  end

  // Reset-cause flags start at the power-on values.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timeout_flag_q <= RST_TO;
      power_down_flag_q <= RST_PD;
    end
    else if (clk_en && go && is_sleep)
    begin
      power_down_flag_q <= 1'h0;
      timeout_flag_q <= 1'h1;
    end
  end

  // Halt stops the oscillator; only the synchronised wake restarts it.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= RSSE_RUN;
      osc_run_q <= 1'h1;
      sleep_q <= 1'h0;
    end
    else if (clk_en)
    begin
      unique case (state_q)
        RSSE_RUN:
        begin
          if (go && is_sleep)
          begin
            state_q <= RSSE_HALT;
            osc_run_q <= 1'h0;
            sleep_q <= 1'h1;
          end
        end
        RSSE_HALT:
        begin
          if (wake_s2_q)
          begin
            state_q <= RSSE_RUN;
            osc_run_q <= 1'h1;
            sleep_q <= 1'h0;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Watchdog counter and prescaler.
  // ****************************************************************

  // Counts while enabled; power-down wins over the count in its cycle.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdt_presc_q <= 8'h00;
      watchdog_counter_q <= 8'h00;
    end
    else if (clk_en)
    begin
      if (go && is_sleep)
      begin
        wdt_presc_q <= 8'h00;
        watchdog_counter_q <= 8'h00;
      end
      else if (wden_q)
      begin
        wdt_presc_q <= wdt_presc_q + 8'h01;
        if (wdt_presc_q == 8'hff)
        begin
          watchdog_counter_q <= watchdog_counter_q + 8'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Register bus.
  // ****************************************************************

  rsse_axil u_bus (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wr_fire(wr_fire),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Watchdog enable; only the low byte lane carries it.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wden_q <= 1'h0;
    end
    else if (clk_en && wr_fire && wr_addr == OFS_CTRL && wr_strb[0])
    begin
      wden_q <= wr_data[CTRL_WDEN];
    end
  end

  // Read decode; unused bits read as zero.
  always_comb
  begin
    rd_data = 32'h0;
    unique case (rd_addr)
      OFS_CTRL: rd_data[CTRL_WDEN] = wden_q;
      OFS_STAT:
      begin
        rd_data[ST_C] = flag_c_q;
        rd_data[ST_DC] = digit_carry_flag_q;
        rd_data[ST_Z] = flag_z_q;
        rd_data[ST_TO] = timeout_flag_q;
        rd_data[ST_PD] = power_down_flag_q;
        rd_data[ST_SLP] = sleep_q;
      end
      OFS_WDOG: rd_data[15:0] = {wdt_presc_q, watchdog_counter_q};
      default: rd_data = 32'h0;
    endcase
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_sleep_issue;
    clk_en && go && is_sleep;
  endsequence
  sequence seq_halted;
    !osc_run_q && sleep_q && !instr_done_q;
  endsequence

  rot_result_a: assert property (clk_en && go && is_rot |=>
    wb_data_q == {$past(file_in[6:0]), $past(carry_in)} &&
    flag_c_q == $past(file_in[7]) && c_we_q && !dcz_we_q)
    else $error("rotate result or carry wrong");
  rot_dest_a: assert property (clk_en && go && is_rot |=>
    f_we_q == $past(instr_word[7]) && w_we_q == !$past(instr_word[7]))
    else $error("rotate destination wrong");
  pd_clear_a: assert property (seq_sleep_issue |=>
    !power_down_flag_q) else $error("power-down flag not cleared");
  to_set_a: assert property (seq_sleep_issue |=>
    timeout_flag_q) else $error("time-out flag not set");
  wdt_clear_a: assert property (seq_sleep_issue |=>
    watchdog_counter_q == 8'h00 && wdt_presc_q == 8'h00)
    else $error("watchdog not cleared");
  osc_halt_a: assert property (seq_sleep_issue ##1 !wake_s2_q |=>
    seq_halted) else $error("oscillator not halted");
  sublit_a: assert property (clk_en && go && is_subl |=>
    wb_data_q == 8'($past(instr_word[7:0]) - $past(w_in)) && dcz_we_q)
    else $error("literal subtract wrong");
  sublit_dest_a: assert property (clk_en && go && is_subl |=>
    w_we_q && !f_we_q) else $error("literal subtract wrote file");
  subf_a: assert property (clk_en && go && is_subf |=>
    wb_data_q == 8'($past(file_in) - $past(w_in)) &&
    flag_z_q == (wb_data_q == 8'h00)) else $error("file subtract wrong");
  subf_dest_a: assert property (clk_en && go && is_subf |=>
    f_we_q == $past(instr_word[7]) && w_we_q == !$past(instr_word[7]))
    else $error("file subtract destination wrong");
  no_borrow_a: assert property (clk_en && go && is_subf &&
    file_in >= w_in |=> flag_c_q) else $error("carry not set");
  borrow_a: assert property (clk_en && go && is_subf &&
    file_in < w_in |=> !flag_c_q) else $error("carry not cleared");
  one_cycle_a: assert property (clk_en && go &&
    (is_rot || is_subf || is_subl || is_sleep) |=> instr_done_q)
    else $error("instruction not done in one cycle");
endmodule : rsse_exec

//--- inc/rsse_pkg.sv
/*
  Constants shared by the rotate, subtract and power-down execution block:
  opcode patterns, register offsets, field positions and reset values.
  Assumes a 14-bit program word and an 8-bit data path.
*/
// Functional notes
// - Rotate left through carry; old carry to bit 0, bit 7 to carry.
// - Rotate result goes to working register if d is 0, file if 1.
// - Power-down opcode clears the power-down flag.
// - Power-down opcode sets the time-out flag.
// - Power-down opcode zeroes the watchdog counter and its prescaler.
// - Power-down opcode enters sleep with the oscillator halted.
// - Literal minus working register, updating carry, digit carry, zero.
// - Subtract from literal always writes the working register only.
// - File minus working register, updating carry, digit carry, zero.
// - Subtract from file goes to working register if d is 0, file if 1.
// - Subtraction with zero or positive result sets carry to 1.
// - Subtraction with negative result clears carry to 0.
package rsse_pkg;
  // ****************************************************************
  // Instruction word layout and opcode patterns.
  // ****************************************************************
  localparam int IW = 14;
  localparam int DW = 8;
  localparam int DEST_BIT = 7;
  localparam int FA_W = 7;
  localparam logic [5:0] OP_ROT = 6'h0d;
  localparam logic [5:0] OP_SUBF = 6'h02;
  localparam logic [4:0] OP_SUBL = 5'h1e;
  localparam logic [13:0] OP_SLEEP = 14'h0063;

  typedef enum logic [1:0] {RSSE_ALU_ROT, RSSE_ALU_SUB} rsse_alu_t;
  typedef enum logic {RSSE_RUN, RSSE_HALT} rsse_state_t;

  // ****************************************************************
  // Register map and bus constants.
  // ****************************************************************
  localparam int AW = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_WDOG = 4'h8;
  localparam int CTRL_WDEN = 0;
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_TO = 3;
  localparam int ST_PD = 4;
  localparam int ST_SLP = 5;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic RST_TO = 1'h1;
  localparam logic RST_PD = 1'h1;

  function automatic logic addr_hit(input logic [3:0] a);
    addr_hit = (a == OFS_CTRL) || (a == OFS_STAT) || (a == OFS_WDOG);
  endfunction : addr_hit
endpackage : rsse_pkg

//--- hdl/rsse_alu.sv
/*
  Combinational datapath for rotate-left-through-carry and subtract.
  Assumes the caller registers the result and picks the destination.
*/
`timescale 1ns/10ps
module rsse_alu
  import rsse_pkg::*;
(
  input wire rsse_alu_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] w,
  input wire logic c_in,
  output logic [7:0] res,
  output logic c_out,
  output logic dc_out,
  output logic z_out
);
  logic [8:0] diff;
  logic [4:0] ndiff;

  // Subtract as a + ~w + 1 so carry out reads as "no borrow".
  assign diff = {1'h0, a} + {1'h0, ~w} + 9'h001;
  assign ndiff = {1'h0, a[3:0]} + {1'h0, ~w[3:0]} + 5'h01;

  // Pick the operation; rotate overrides only result and carry, zero always follows the subtract.
  always_comb
  begin
    res = diff[7:0];
    c_out = diff[8];
    dc_out = ndiff[4];
    z_out = (diff[7:0] == 8'h00);
    if (op == RSSE_ALU_ROT)
    begin
      res = {a[6:0], c_in};
      c_out = a[7];
    end
  end
endmodule : rsse_alu

//--- hdl/rsse_axil.sv
/*
  AXI4-Lite slave front end. Takes address and data in either order,
  raises a one-cycle write strobe, and answers reads one cycle after the
  address. Assumes rd_data is decoded combinationally from rd_addr.
*/
`timescale 1ns/10ps
module rsse_axil
  import rsse_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic wr_fire,
  output logic [3:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [3:0] rd_addr,
  input wire logic [31:0] rd_data
);
  logic aw_full_q;
  logic w_full_q;
  logic rd_pend_q;

  assign wr_fire = aw_full_q && w_full_q && !bvalid;

  // Write channel; both halves are held until the response is taken.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awready <= 1'h1;
      wready <= 1'h1;
      aw_full_q <= 1'h0;
      w_full_q <= 1'h0;
      bvalid <= 1'h0;
      bresp <= RESP_OK;
      wr_addr <= 4'h0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
    end
    else if (clk_en)
    begin
      if (awvalid && awready)
      begin
        wr_addr <= awaddr;
        aw_full_q <= 1'h1;
        awready <= 1'h0;
      end
      if (wvalid && wready)
      begin
        wr_data <= wdata;
        wr_strb <= wstrb;
        w_full_q <= 1'h1;
        wready <= 1'h0;
      end
      if (wr_fire)
      begin
        bvalid <= 1'h1;
        bresp <= addr_hit(wr_addr) ? RESP_OK : RESP_ERR;
        aw_full_q <= 1'h0;
        w_full_q <= 1'h0;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'h0;
        awready <= 1'h1;
        wready <= 1'h1;
      end
    end
  end

  // Read channel; unmapped reads return zero with a slave error.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready <= 1'h1;
      rd_pend_q <= 1'h0;
      rd_addr <= 4'h0;
      rvalid <= 1'h0;
      rdata <= 32'h0;
      rresp <= RESP_OK;
    end
    else if (clk_en)
    begin
      if (arvalid && arready)
      begin
        rd_addr <= araddr;
        rd_pend_q <= 1'h1;
        arready <= 1'h0;
      end
      if (rd_pend_q)
      begin
        rd_pend_q <= 1'h0;
        rvalid <= 1'h1;
        rdata <= rd_data;
        rresp <= addr_hit(rd_addr) ? RESP_OK : RESP_ERR;
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'h0;
        arready <= 1'h1;
      end
    end
  end
endmodule : rsse_axil

//--- testbench/rsse_regfile_model.sv
/*
  Behavioural model of the far side: working register, file registers
  and carry flag, read back in the same cycle.
  Assumes one-cycle write strobes from the execution block on core_clk.
*/
`timescale 1ns/10ps
module rsse_regfile_model
(
  input wire logic core_clk,
  input wire logic [6:0] rd_addr,
  input wire logic w_we,
  input wire logic f_we,
  input wire logic [6:0] f_addr,
  input wire logic [7:0] wb_data,
  input wire logic c_we,
  input wire logic c_val,
  output logic [7:0] w_in,
  output logic [7:0] file_in,
  output logic carry_in
);
  // ****************************************************************
  // Storage, preloaded by the bench through hierarchical writes.
  // ****************************************************************
  logic [7:0] w_q;
  logic [7:0] mem_q [0:127];
  logic c_q;

  // Operands go out combinationally, since the block wants them in the
  // same cycle as the word.
  assign w_in = w_q;
  assign file_in = mem_q[rd_addr];
  assign carry_in = c_q;

  // Write-back on the strobes; a plain always lets the bench preload too.
  always @(posedge core_clk)
  begin
    if (w_we)
      w_q <= wb_data;
    if (f_we)
      mem_q[f_addr] <= wb_data;
    if (c_we)
      c_q <= c_val;
  end
endmodule : rsse_regfile_model

//--- testbench/tb_top.sv
/*
  Self-checking bench for the execution block with a register file model.
  Assumes registered outputs, a one-cycle answer and AXI4-Lite access.
*/
`timescale 1ns/10ps
module tb_top;
  import rsse_pkg::*;
  // ****************************************************************
  // Signals, clock and instances.
  // ****************************************************************
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic instr_valid = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic wake_pin = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0;
  logic [7:0] w_in, file_in, wb_data_q, watchdog_counter_q, wdt_presc_q;
  logic [6:0] f_addr_q;
  logic carry_in, instr_done_q, w_we_q, f_we_q, c_we_q, dcz_we_q;
  logic flag_c_q, digit_carry_flag_q, flag_z_q, timeout_flag_q;
  logic power_down_flag_q, osc_run_q, sleep_q;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;

  always #2 core_clk = ~core_clk;

  rsse_exec rsse_exec_i (.core_clk, .rst_n, .clk_en, .instr_valid,
    .instr_word, .w_in, .file_in, .carry_in, .wake_pin, .instr_done_q,
    .w_we_q, .f_we_q, .f_addr_q, .wb_data_q, .c_we_q, .dcz_we_q,
    .flag_c_q, .digit_carry_flag_q, .flag_z_q, .timeout_flag_q,
    .power_down_flag_q, .osc_run_q, .sleep_q, .watchdog_counter_q,
    .wdt_presc_q, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp);

  rsse_regfile_model m (.core_clk, .rd_addr(instr_word[6:0]),
    .w_we(w_we_q), .f_we(f_we_q), .f_addr(f_addr_q), .wb_data(wb_data_q),
    .c_we(c_we_q), .c_val(flag_c_q), .w_in, .file_in, .carry_in);

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // A hang must still reach the report, so it counts as a mismatch.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Ready is read as sampled at the edge; outputs are all registered.
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (1)
    begin
      @(posedge core_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    @(posedge core_clk);
  endtask : axw

  task automatic axr(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (1)
    begin
      @(posedge core_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    @(posedge core_clk);
  endtask : axr

  // One word, taken at the next edge; the answer stands for one cycle
  // after that edge, so it is sampled just past it and no later.
  task automatic issue(input logic [13:0] word);
    instr_word <= word;
    instr_valid <= 1'b1;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
  endtask : issue

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_rot(input logic d, input logic [7:0] f, input logic c);
    m.mem_q[7'h15] <= f;
    m.c_q <= c;
    issue({OP_ROT, d, 7'h15});
    chk("done", 1, instr_done_q);
    chk("w_we", !d, w_we_q);
    chk("f_we", d, f_we_q);
    chk("c_we", 1, c_we_q);
    chk("dcz_we", 0, dcz_we_q);
    chk("rot", {f[6:0], c}, wb_data_q);
    chk("carry", f[7], flag_c_q);
    @(posedge core_clk);
    #1;
    chk("dest", {f[6:0], c}, d ? m.mem_q[7'h15] : m.w_q);
    chk("pulse", 0, instr_done_q);
    @(posedge core_clk);
  endtask : t_rot

  // Literal form uses d as the don't-care bit, which must not matter.
  task automatic t_sub(input logic lit, input logic d,
                       input logic [7:0] a, input logic [7:0] w);
    m.mem_q[7'h15] <= a;
    m.w_q <= w;
    issue(lit ? {OP_SUBL, d, a} : {OP_SUBF, d, 7'h15});
    chk("w_we", lit || !d, w_we_q);
    chk("f_we", !lit && d, f_we_q);
    chk("diff", 8'(a - w), wb_data_q);
    chk("carry", a >= w, flag_c_q);
    chk("dc", a[3:0] >= w[3:0], digit_carry_flag_q);
    chk("zero", a == w, flag_z_q);
    chk("dcz_we", 1, dcz_we_q);
    // Let the model take the write-back before the next preload.
    @(posedge core_clk);
    #1;
    chk("dest", 8'(a - w), (!lit && d) ? m.mem_q[7'h15] : m.w_q);
    @(posedge core_clk);
  endtask : t_sub

  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    axr(OFS_STAT, d, r);
    chk("stat_rst", 3'b011, d[5:3]);
    axw(4'hc, 32'h1, r);
    chk("bresp", RESP_ERR, r);
    axr(4'hc, d, r);
    chk("rresp", RESP_ERR, r);
    chk("rdata", 0, d);
    axw(OFS_CTRL, 32'h1, r);
    chk("bresp_ok", RESP_OK, r);
    axr(OFS_CTRL, d, r);
    chk("ctrl", 1, d);
  endtask : t_bus

  task automatic t_sleep;
    logic [31:0] d;
    logic [1:0] r;
    repeat (300) @(posedge core_clk);
    chk("wdt_run", 1, |{watchdog_counter_q, wdt_presc_q});
    issue(OP_SLEEP);
    chk("done", 1, instr_done_q);
    chk("pd", 0, power_down_flag_q);
    chk("to", 1, timeout_flag_q);
    chk("wdt", 0, {watchdog_counter_q, wdt_presc_q});
    chk("osc", 0, osc_run_q);
    chk("sleep", 1, sleep_q);
    @(posedge core_clk);
    issue({OP_ROT, 1'b0, 7'h15});
    chk("refused", 0, instr_done_q);
    @(posedge core_clk);
    wake_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    wake_pin <= 1'b0;
    #1;
    chk("awake", 2'b10, {osc_run_q, sleep_q});
    @(posedge core_clk);
    axr(OFS_STAT, d, r);
    chk("stat_pd_to", 2'b01, d[4:3]);
  endtask : t_sleep

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_bus();
    t_rot(1'b0, 8'he6, 1'b0);
    t_rot(1'b1, 8'h5a, 1'b1);
    t_sub(1'b1, 1'b0, 8'h02, 8'h01);
    t_sub(1'b1, 1'b1, 8'h02, 8'h02);
    t_sub(1'b1, 1'b0, 8'h02, 8'h03);
    t_sub(1'b1, 1'b0, 8'h90, 8'h01);
    t_sub(1'b0, 1'b1, 8'h03, 8'h02);
    t_sub(1'b0, 1'b0, 8'h02, 8'h02);
    t_sub(1'b0, 1'b1, 8'h01, 8'h02);
    t_sleep();
    give_verdict();
  end
endmodule : tb_top
